// >>> logic/dtcu_counter.sv
`timescale 1ns/1ps
module dtcu_counter (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic tick_in,
	input wire logic load_in,
	input wire logic [15:0] load_val_in,
	input wire logic preset_in,
	input wire logic [15:0] reload_val_in,
	output logic [15:0] count_out,
	output logic underflow_out
);
	import dtcu_pkg::*;

	logic [15:0] count_reg;
	logic [15:0] count_next;

	// Software load beats preset, preset beats counting
	assign underflow_out = tick_in & (count_reg == 16'h0000) & ~load_in & ~preset_in;
	assign count_next = load_in ? load_val_in :
		preset_in ? PRESET_VAL :
		underflow_out ? reload_val_in :
		tick_in ? count_reg - 16'h0001 : count_reg;

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count_reg <= RST_COUNT;
		end else begin
			count_reg <= count_next;
		end
	end

	assign count_out = count_reg;
endmodule

// >>> logic/dtcu_sync.sv
`timescale 1ns/1ps
module dtcu_sync (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic async_in,
	output logic level_out,
	output logic rise_out,
	output logic fall_out
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// Two-stage synchroniser plus one stage for edge history
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Edges seen only after the second stage
	assign level_out = sync_reg;
	assign rise_out = sync_reg & ~prev_reg;
	assign fall_out = ~sync_reg & prev_reg;
endmodule

// >>> logic/dtcu_top.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module dtcu_top (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic pin_a_in,
	output logic pin_a_out,
	output logic pin_a_oe_out,
	input wire logic pin_b_in,
	output logic timer_int1_out,
	output logic timer_int2_out
);
	import dtcu_pkg::*;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [4:0] psc_reg;
	logic [5:0] csel_reg;
	logic [7:0] ctl_reg;
	logic [7:0] ctl_next;
	logic [3:0] ien_reg;
	logic [3:0] pend_reg;
	logic [3:0] pend_next;
	logic [15:0] rca_reg;
	logic [15:0] rca_next;
	logic [15:0] rcb_reg;
	logic [15:0] rcb_next;
	logic [4:0] pcnt_reg;
	logic [4:0] pcnt_next;
	logic sel_b_reg;
	logic sel_b_next;
	logic [31:0] prdata_reg;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire setup_ph = psel_in & ~penable_in;
	wire access_ph = psel_in & penable_in;
	wire hit_cnt1 = (paddr_in == ADDR_CNT1);
	wire hit_rca = (paddr_in == ADDR_RCA);
	wire hit_rcb = (paddr_in == ADDR_RCB);
	wire hit_cnt2 = (paddr_in == ADDR_CNT2);
	wire hit_psc = (paddr_in == ADDR_PSC);
	wire hit_csel = (paddr_in == ADDR_CSEL);
	wire hit_ctl = (paddr_in == ADDR_CTL);
	wire hit_ictl = (paddr_in == ADDR_ICTL);
	wire hit_iclr = (paddr_in == ADDR_ICLR);
	wire hit_any = hit_cnt1 | hit_rca | hit_rcb | hit_cnt2 | hit_psc | hit_csel |
		hit_ctl | hit_ictl | hit_iclr;
	wire wr_ok = access_ph & pwrite_in;
	wire wr_cnt1 = wr_ok & hit_cnt1;
	wire wr_rca = wr_ok & hit_rca;
	wire wr_rcb = wr_ok & hit_rcb;
	wire wr_cnt2 = wr_ok & hit_cnt2;
	wire wr_psc = wr_ok & hit_psc;
	wire wr_csel = wr_ok & hit_csel;
	wire wr_ctl = wr_ok & hit_ctl;
	wire wr_ictl = wr_ok & hit_ictl;
	wire wr_iclr = wr_ok & hit_iclr;

	// Zero wait states: read data is latched in the setup cycle
	assign pready_out = 1'b1;
	assign pslverr_out = access_ph & ~hit_any;

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	wire [1:0] mode = ctl_reg[1:0];
	wire run_en = ctl_reg[CTL_POS_ENABLE];
	wire pa_func = ctl_reg[CTL_POS_PA_FUNC];
	wire pb_preset = ctl_reg[CTL_POS_PB_PRESET];
	wire [2:0] c1_sel = csel_reg[CSEL_POS_C1 +: 3];
	wire [2:0] c2_sel = csel_reg[CSEL_POS_C2 +: 3];
	wire is_pwm = (mode == MODE_PWM);
	wire is_dcap = (mode == MODE_DCAP);
	wire is_ind = (mode == MODE_IND);
	wire is_capt = (mode == MODE_CAPT);
	wire cap_mode = is_dcap | is_capt;

	// ------------------------------------------------------------
	// Pin synchronisers and edge selection
	// ------------------------------------------------------------
	logic pa_rise;
	logic pa_fall;
	logic pb_lvl;
	logic pb_rise;
	logic pb_fall;

	// Pin B pulses shorter than a clock may be missed
	dtcu_sync u_sync_a (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.async_in(pin_a_in),
		.level_out(),
		.rise_out(pa_rise),
		.fall_out(pa_fall)
	);
	dtcu_sync u_sync_b (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.async_in(pin_b_in),
		.level_out(pb_lvl),
		.rise_out(pb_rise),
		.fall_out(pb_fall)
	);

	// Edge bit high selects rising, low selects falling
	wire pa_edge = ctl_reg[CTL_POS_PA_EDGE] ? pa_rise : pa_fall;
	wire pb_edge = ctl_reg[CTL_POS_PB_EDGE] ? pb_rise : pb_fall;
	wire pb_acc = ctl_reg[CTL_POS_PB_EDGE] ? pb_lvl : ~pb_lvl;

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	wire psc_tick = run_en & (pcnt_reg == psc_reg);
	assign pcnt_next = (!run_en || psc_tick) ? 5'h00 : pcnt_reg + 5'h01;

	// Clock pick; pin B sources are refused in capture modes
	function automatic logic clk_pick(input logic [2:0] sel, input logic cap,
		input logic tick, input logic edge_ev, input logic acc);
		clk_pick = (sel == CS_PRESC && tick) ||
			(!cap && sel == CS_EVENT && edge_ev) ||
			(!cap && sel == CS_ACCUM && tick && acc);
	endfunction

	// Zero code never ticks, so the counter holds
	wire c1_tick = run_en & clk_pick(c1_sel, cap_mode, psc_tick, pb_edge, pb_acc);
	wire c2_tick = run_en & clk_pick(c2_sel, cap_mode, psc_tick, pb_edge, pb_acc);

	// ------------------------------------------------------------
	// Captures and presets
	// ------------------------------------------------------------
	wire cap_a1 = run_en & is_dcap & pa_edge;
	wire cap_b1 = run_en & is_dcap & pb_edge;
	wire cap_b2 = run_en & is_capt & pb_edge;
	wire c1_preset = (cap_a1 & pa_func) | (cap_b1 & pb_preset);
	wire c2_preset = cap_b2 & pb_preset;

	// ------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------
	logic [15:0] c1_cnt;
	logic [15:0] c2_cnt;
	logic c1_uf;
	logic c2_uf;

	// PWM alternates reload sources; capture counters run free
	wire [15:0] c1_reload = is_dcap ? PRESET_VAL : (is_pwm && sel_b_reg) ? rcb_reg : rca_reg;
	wire [15:0] c2_reload = is_capt ? PRESET_VAL : rcb_reg;

	dtcu_counter u_cnt1 (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.tick_in(c1_tick),
		.load_in(wr_cnt1),
		.load_val_in(pwdata_in[15:0]),
		.preset_in(c1_preset),
		.reload_val_in(c1_reload),
		.count_out(c1_cnt),
		.underflow_out(c1_uf)
	);
	dtcu_counter u_cnt2 (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.tick_in(c2_tick),
		.load_in(wr_cnt2),
		.load_val_in(pwdata_in[15:0]),
		.preset_in(c2_preset),
		.reload_val_in(c2_reload),
		.count_out(c2_cnt),
		.underflow_out(c2_uf)
	);

	// PWM reload alternation restarts from the first register
	assign sel_b_next = (!is_pwm || c1_sel == CS_STOP) ? 1'b0 : c1_uf ? ~sel_b_reg : sel_b_reg;

	// Captured value wins over a software write in the same cycle
	assign rca_next = cap_a1 ? c1_cnt : wr_rca ? pwdata_in[15:0] : rca_reg;
	assign rcb_next = cap_b1 ? c1_cnt : cap_b2 ? c2_cnt : wr_rcb ? pwdata_in[15:0] : rcb_reg;

	// ------------------------------------------------------------
	// Pin A output
	// ------------------------------------------------------------
	wire pa_toggle = c1_uf & pa_func & ~is_dcap;
	wire pa_rise_tog = pa_toggle & ~ctl_reg[CTL_POS_PA_LEVEL];
	logic [7:0] ctl_tog;

	// Level bit is the pin; software may preset it before starting
	always_comb begin
		ctl_tog = ctl_reg;
		ctl_tog[CTL_POS_PA_LEVEL] = ~ctl_reg[CTL_POS_PA_LEVEL];
	end
	assign ctl_next = wr_ctl ? pwdata_in[7:0] : pa_toggle ? ctl_tog : ctl_reg;
	assign pin_a_out = ctl_reg[CTL_POS_PA_LEVEL];
	assign pin_a_oe_out = ~is_dcap;

	// ------------------------------------------------------------
	// Pending flags and interrupts
	// ------------------------------------------------------------
	wire set_a = is_dcap ? cap_a1 : is_pwm ? (c1_uf & ~sel_b_reg) : c1_uf;
	wire set_b = is_dcap ? cap_b1 : is_capt ? cap_b2 : is_pwm ? (c1_uf & sel_b_reg) : 1'b0;
	wire set_c = is_dcap ? c1_uf : is_pwm ? 1'b0 : pa_rise_tog;
	wire set_d = c2_uf;
	wire [3:0] set_vec = {set_d, set_c, set_b, set_a};
	wire [3:0] clr_vec = wr_iclr ? pwdata_in[ICTL_POS_PEND +: 4] : 4'h0;

	// Set wins over clear so no event is lost
	assign pend_next = (pend_reg & ~clr_vec) | set_vec;
	wire [3:0] req_vec = pend_reg & ien_reg;
	assign timer_int1_out = |req_vec[2:0];
	assign timer_int2_out = req_vec[3];

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	wire [31:0] rd_data = hit_cnt1 ? {16'h0000, c1_cnt} :
		hit_rca ? {16'h0000, rca_reg} :
		hit_rcb ? {16'h0000, rcb_reg} :
		hit_cnt2 ? {16'h0000, c2_cnt} :
		hit_psc ? {27'h0000000, psc_reg} :
		hit_csel ? {26'h0000000, csel_reg} :
		hit_ctl ? {24'h000000, ctl_reg} :
		hit_ictl ? {24'h000000, pend_reg, ien_reg} : 32'h00000000;
	assign prdata_out = prdata_reg;

	// ------------------------------------------------------------
	// Register updates
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			psc_reg <= RST_PSC;
			csel_reg <= RST_CSEL;
			ien_reg <= RST_IRQ;
			prdata_reg <= 32'h00000000;
		end else begin
			if (wr_psc) begin
				psc_reg <= pwdata_in[4:0];
			end
			if (wr_csel) begin
				csel_reg <= pwdata_in[5:0];
			end
			if (wr_ictl) begin
				ien_reg <= pwdata_in[3:0];
			end
			if (setup_ph && !pwrite_in) begin
				prdata_reg <= rd_data;
			end
		end
	end

	// Block state
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctl_reg <= RST_CTL;
			pend_reg <= RST_IRQ;
			rca_reg <= RST_COUNT;
			rcb_reg <= RST_COUNT;
			pcnt_reg <= RST_PSC;
			sel_b_reg <= 1'b0;
		end else begin
			ctl_reg <= ctl_next;
			pend_reg <= pend_next;
			rca_reg <= rca_next;
			rcb_reg <= rcb_next;
			pcnt_reg <= pcnt_next;
			sel_b_reg <= sel_b_next;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_psc_gap;
		(psc_tick && psc_reg != 5'h00 && !wr_psc) |=> !psc_tick;
	endproperty
	a_psc_gap: assert property (p_psc_gap) else $error("prescaler ticked twice");

	property p_reload1;
		(c1_uf && !wr_cnt1 && (is_ind || is_capt)) |=> (c1_cnt == $past(rca_reg));
	endproperty
	a_reload1: assert property (p_reload1) else $error("counter one bad reload");

	property p_toggle;
		(pa_toggle && !wr_ctl && is_ind) |=> (pin_a_out != $past(pin_a_out));
	endproperty
	a_toggle: assert property (p_toggle) else $error("pin a did not toggle");

	property p_no_toggle;
		(!pa_func && !wr_ctl && (is_ind || is_capt)) |=> $stable(pin_a_out);
	endproperty
	a_no_toggle: assert property (p_no_toggle) else $error("pin a toggled while off");

	property p_pend_c;
		pa_rise_tog |=> pend_reg[2];
	endproperty
	a_pend_c: assert property (p_pend_c) else $error("pending c not set");

	property p_pend_d;
		(c2_uf && is_ind) |=> pend_reg[3];
	endproperty
	a_pend_d: assert property (p_pend_d) else $error("pending d not set");

	property p_cap_b;
		cap_b2 |=> (rcb_reg == $past(c2_cnt)) && pend_reg[1];
	endproperty
	a_cap_b: assert property (p_cap_b) else $error("capture into second reg failed");

	property p_preset;
		(cap_b2 && pb_preset && !wr_cnt2) |=> (c2_cnt == PRESET_VAL);
	endproperty
	a_preset: assert property (p_preset) else $error("counter two not preset");

	property p_stop_ext;
		(is_capt && c1_sel == CS_EVENT && !wr_cnt1 && !c1_preset) |=> $stable(c1_cnt);
	endproperty
	a_stop_ext: assert property (p_stop_ext) else $error("counter ran on pin clock");

	property p_stop_zero;
		(c2_sel == CS_STOP && !wr_cnt2 && !c2_preset) |=> $stable(c2_cnt);
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("stopped counter moved");

	property p_int2;
		(set_d && ien_reg[3] && !wr_ictl) |=> timer_int2_out;
	endproperty
	a_int2: assert property (p_int2) else $error("interrupt two missing");

	property p_clear;
		(wr_iclr && pwdata_in[ICTL_POS_PEND] && !set_a) |=> !pend_reg[0];
	endproperty
	a_clear: assert property (p_clear) else $error("pending a not cleared");

	c_toggle: cover property (pa_toggle ##1 pin_a_out);
	c_capture: cover property (cap_b2 && pb_preset);
	c_int1: cover property (timer_int1_out ##1 !timer_int1_out);
	c_pwm_alt: cover property (is_pwm && c1_uf && sel_b_reg);
endmodule

// >>> pkg/dtcu_pkg.sv
package dtcu_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [23:0] IDX_CNT1 = 24'hFFFF40;
	localparam logic [23:0] IDX_RCA = 24'hFFFF42;
	localparam logic [23:0] IDX_RCB = 24'hFFFF44;
	localparam logic [23:0] IDX_CNT2 = 24'hFFFF46;
	localparam logic [23:0] IDX_PSC = 24'hFFFF48;
	localparam logic [23:0] IDX_CSEL = 24'hFFFF4A;
	localparam logic [23:0] IDX_CTL = 24'hFFFF4C;
	localparam logic [23:0] IDX_ICTL = 24'hFFFF4E;
	localparam logic [23:0] IDX_ICLR = 24'hFFFF50;

	localparam logic [31:0] ADDR_CNT1 = {6'h00, IDX_CNT1, 2'h0};
	localparam logic [31:0] ADDR_RCA = {6'h00, IDX_RCA, 2'h0};
	localparam logic [31:0] ADDR_RCB = {6'h00, IDX_RCB, 2'h0};
	localparam logic [31:0] ADDR_CNT2 = {6'h00, IDX_CNT2, 2'h0};
	localparam logic [31:0] ADDR_PSC = {6'h00, IDX_PSC, 2'h0};
	localparam logic [31:0] ADDR_CSEL = {6'h00, IDX_CSEL, 2'h0};
	localparam logic [31:0] ADDR_CTL = {6'h00, IDX_CTL, 2'h0};
	localparam logic [31:0] ADDR_ICTL = {6'h00, IDX_ICTL, 2'h0};
	localparam logic [31:0] ADDR_ICLR = {6'h00, IDX_ICLR, 2'h0};

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTL_POS_ENABLE = 7;
	localparam int CTL_POS_PA_LEVEL = 6;
	localparam int CTL_POS_PB_PRESET = 5;
	localparam int CTL_POS_PA_FUNC = 4;
	localparam int CTL_POS_PB_EDGE = 3;
	localparam int CTL_POS_PA_EDGE = 2;
	localparam int CSEL_POS_C1 = 0;
	localparam int CSEL_POS_C2 = 3;
	localparam int ICTL_POS_PEND = 4;

	// ------------------------------------------------------------
	// Encodings and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_PWM = 2'h0;
	localparam logic [1:0] MODE_DCAP = 2'h1;
	localparam logic [1:0] MODE_IND = 2'h2;
	localparam logic [1:0] MODE_CAPT = 2'h3;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_PRESC = 3'h1;
	localparam logic [2:0] CS_EVENT = 3'h2;
	localparam logic [2:0] CS_ACCUM = 3'h3;
	localparam logic [15:0] PRESET_VAL = 16'hFFFF;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [4:0] RST_PSC = 5'h00;
	localparam logic [5:0] RST_CSEL = 6'h00;
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [3:0] RST_IRQ = 4'h0;

endpackage

// >>> testbench/dtcu_pin_model.sv
`timescale 1ns/1ps
module dtcu_pin_model (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic b_pulse_in,
	input wire logic b_hold_in,
	input wire logic ext_a_level_in,
	input wire logic drv_a_in,
	input wire logic oe_a_in,
	output logic pin_a_line_out,
	output logic pin_b_line_out
);
	logic [1:0] b_left_reg;

	// ------------------------------------------------------------
	// External source on pin B
	// ------------------------------------------------------------
	// Two clocks high, so the pulse never slips between samples
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			b_left_reg <= 2'h0;
		end else if (b_pulse_in) begin
			b_left_reg <= 2'h2;
		end else if (b_left_reg != 2'h0) begin
			b_left_reg <= b_left_reg - 2'h1;
		end
	end

	// Held level gives a slow source, strobe a prompt one
	assign pin_b_line_out = b_hold_in | (b_left_reg != 2'h0);
	// Shared pin A: device drives it unless its enable is low
	assign pin_a_line_out = oe_a_in ? drv_a_in : ext_a_level_in;
endmodule

// >>> testbench/dual_timer_capture_unit_bench.sv
`timescale 1ns/1ps
module dual_timer_capture_unit_bench;
	import dtcu_pkg::*;
	typedef struct packed {logic wr; logic [31:0] a; logic [31:0] d; logic err;} dtcu_row_s;
	logic sys_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, pin_a_out, pin_a_oe, pin_a_line, pin_b_line, int1, int2;
	logic b_pulse = 1'b0;
	logic b_hold = 1'b0;
	logic [31:0] q, c;
	logic e;
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	int t0, t1, t2;

	// Register table: reset values, reserved bits, unmapped place
	localparam dtcu_row_s ROWS [22] = '{
		'{1'b0, ADDR_CNT1, 32'h0, 1'b0}, '{1'b0, ADDR_RCA, 32'h0, 1'b0},
		'{1'b0, ADDR_RCB, 32'h0, 1'b0}, '{1'b0, ADDR_CNT2, 32'h0, 1'b0},
		'{1'b0, ADDR_PSC, 32'h0, 1'b0}, '{1'b0, ADDR_CSEL, 32'h0, 1'b0},
		'{1'b0, ADDR_CTL, 32'h0, 1'b0}, '{1'b0, ADDR_ICTL, 32'h0, 1'b0},
		'{1'b1, ADDR_PSC, 32'hFFFFFFFF, 1'b0}, '{1'b0, ADDR_PSC, 32'h1F, 1'b0},
		'{1'b1, ADDR_CSEL, 32'hFFFFFFFF, 1'b0}, '{1'b0, ADDR_CSEL, 32'h3F, 1'b0},
		'{1'b1, ADDR_CSEL, 32'h0, 1'b0}, '{1'b1, ADDR_ICTL, 32'hFF, 1'b0},
		'{1'b0, ADDR_ICTL, 32'h0F, 1'b0}, '{1'b0, ADDR_ICLR, 32'h0, 1'b0},
		'{1'b1, ADDR_RCA, 32'hABCD, 1'b0}, '{1'b0, ADDR_RCA, 32'hABCD, 1'b0},
		'{1'b1, ADDR_CNT2, 32'h1234, 1'b0}, '{1'b0, ADDR_CNT2, 32'h1234, 1'b0},
		'{1'b1, 32'h10, 32'h5A, 1'b1}, '{1'b0, 32'h10, 32'h0, 1'b1}};

	// ------------------------------------------------------------
	// Clock, cycle count and instances
	// ------------------------------------------------------------
	always #5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) cyc <= cyc + 1;

	dtcu_top i_dtcu_top (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.pin_a_in(pin_a_line), .pin_a_out(pin_a_out), .pin_a_oe_out(pin_a_oe),
		.pin_b_in(pin_b_line), .timer_int1_out(int1), .timer_int2_out(int2));

	dtcu_pin_model i_dtcu_pin_model (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.b_pulse_in(b_pulse), .b_hold_in(b_hold), .ext_a_level_in(1'b0),
		.drv_a_in(pin_a_out), .oe_a_in(pin_a_oe), .pin_a_line_out(pin_a_line),
		.pin_b_line_out(pin_b_line));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask

	task automatic give_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic timed_out(input string what);
		$display("BAD %s expected done seen timeout", what);
		failures++;
		give_verdict();
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_in);
		penable <= 1'b1;
		@(posedge sys_clk_in);
		while (pready !== 1'b1) begin
			if (n > 50) timed_out("pready");
			n++;
			@(posedge sys_clk_in);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk_in);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		chk(name, exp, q);
	endtask

	// Edge of pin A output, bounded so a dead timer cannot hang
	task automatic wait_a(output int t);
		logic l;
		int n;
		l = pin_a_out;
		n = 0;
		while (pin_a_out === l) begin
			if (n > 300) timed_out("pin a toggle");
			n++;
			@(posedge sys_clk_in);
		end
		t = cyc;
	endtask

	task automatic pulse_b(input int n);
		repeat (n) begin
			b_pulse <= 1'b1;
			@(posedge sys_clk_in);
			b_pulse <= 1'b0;
			repeat (8) @(posedge sys_clk_in);
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		@(posedge sys_clk_in);
		foreach (ROWS[i]) begin
			apb(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
			if (!ROWS[i].wr) chk($sformatf("row %0d data", i), ROWS[i].d, q);
			chk($sformatf("row %0d error", i), {31'h0, ROWS[i].err}, {31'h0, e});
		end
		// Pin A is only released in dual capture mode
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_CTL, 32'h80 | 32'(m));
			chk("pin a enable", {31'h0, m != 1}, {31'h0, pin_a_oe});
		end
		// Square wave: divide 4, reload 3, so 16 cycles per half
		wr(ADDR_PSC, 32'h3);
		wr(ADDR_CNT1, 32'h3);
		wr(ADDR_RCA, 32'h3);
		wr(ADDR_ICTL, 32'h5);
		wr(ADDR_CTL, 32'h92);
		wr(ADDR_CSEL, 32'h1);
		wait_a(t0);
		wait_a(t1);
		wait_a(t2);
		chk("half period one", 32'd16, 32'(t1 - t0));
		chk("half period two", 32'd16, 32'(t2 - t1));
		rd(ADDR_ICTL, 32'h55, "pending a and c");
		chk("int one", 32'h1, {31'h0, int1});
		chk("int two", 32'h0, {31'h0, int2});
		wr(ADDR_CSEL, 32'h0);
		apb(1'b0, ADDR_CNT1, 32'h0);
		c = q;
		repeat (20) @(posedge sys_clk_in);
		rd(ADDR_CNT1, c, "stopped count");
		wr(ADDR_ICTL, 32'h0);
		rd(ADDR_ICTL, 32'h50, "pending kept");
		chk("int one masked", 32'h0, {31'h0, int1});
		wr(ADDR_ICLR, 32'h0);
		rd(ADDR_ICTL, 32'h50, "clear with zero");
		wr(ADDR_ICLR, 32'h50);
		rd(ADDR_ICTL, 32'h0, "clear with one");
		// Start level set before the clock runs; no toggle with function off
		wr(ADDR_CTL, 32'hC2);
		chk("pin a start level", 32'h1, {31'h0, pin_a_out});
		wr(ADDR_CSEL, 32'h1);
		repeat (40) @(posedge sys_clk_in);
		chk("pin a held", 32'h1, {31'h0, pin_a_out});
		rd(ADDR_ICTL, 32'h10, "reload sets a only");
		wr(ADDR_CSEL, 32'h0);
		wr(ADDR_ICLR, 32'hF0);
		// Both counters clocked by rising events on pin B
		wr(ADDR_CTL, 32'h8A);
		wr(ADDR_RCB, 32'h7);
		wr(ADDR_CNT2, 32'h2);
		wr(ADDR_CNT1, 32'h5);
		wr(ADDR_ICTL, 32'h8);
		wr(ADDR_CSEL, 32'h12);
		pulse_b(2);
		rd(ADDR_CNT2, 32'h0, "two events");
		chk("int two early", 32'h0, {31'h0, int2});
		pulse_b(1);
		rd(ADDR_CNT2, 32'h7, "reload two");
		rd(ADDR_CNT1, 32'h2, "counter one events");
		rd(ADDR_ICTL, 32'h88, "pending d");
		chk("int two", 32'h1, {31'h0, int2});
		chk("int one quiet", 32'h0, {31'h0, int1});
		// Pulse accumulate: prescaler ticks counted only while pin B is high
		wr(ADDR_CNT1, 32'h100);
		wr(ADDR_CSEL, 32'h3);
		repeat (10) @(posedge sys_clk_in);
		rd(ADDR_CNT1, 32'h100, "accumulate idle");
		b_hold <= 1'b1;
		repeat (40) @(posedge sys_clk_in);
		b_hold <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
		apb(1'b0, ADDR_CNT1, 32'h0);
		chk("accumulate count", 32'h1, {31'h0, q >= 32'hF4 && q <= 32'hF8});
		wr(ADDR_CSEL, 32'h0);
		wr(ADDR_ICLR, 32'hF0);
		// Capture plus timer with preset; counter two kept on prescaler
		wr(ADDR_PSC, 32'h0);
		wr(ADDR_CNT1, 32'h50);
		wr(ADDR_CNT2, 32'h1000);
		wr(ADDR_ICTL, 32'h2);
		wr(ADDR_CTL, 32'hAB);
		wr(ADDR_CSEL, 32'h0A);
		pulse_b(1);
		apb(1'b0, ADDR_RCB, 32'h0);
		chk("capture value", 32'h1, {31'h0, q <= 32'h1000 && q >= 32'hFC0});
		apb(1'b0, ADDR_CNT2, 32'h0);
		chk("preset count", 32'hFF, {24'h0, q[15:8]});
		rd(ADDR_CNT1, 32'h50, "event clock stopped");
		rd(ADDR_ICTL, 32'h22, "pending b");
		chk("int one capture", 32'h1, {31'h0, int1});
		// Falling polarity: rising edge ignored, falling edge captures
		wr(ADDR_CTL, 32'hA3);
		wr(ADDR_ICLR, 32'h20);
		b_hold <= 1'b1;
		repeat (8) @(posedge sys_clk_in);
		rd(ADDR_ICTL, 32'h02, "rise ignored");
		b_hold <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
		rd(ADDR_ICTL, 32'h22, "fall captured");
		// Reset in mid-run: state back to zero, bus usable at once after
		nrst_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		chk("pin a in reset", 32'h0, {31'h0, pin_a_out});
		chk("pin a enable in reset", 32'h1, {31'h0, pin_a_oe});
		chk("ready in reset", 32'h1, {31'h0, pready});
		chk("int one in reset", 32'h0, {31'h0, int1});
		nrst_in <= 1'b1;
		@(posedge sys_clk_in);
		rd(ADDR_CTL, 32'h0, "control after reset");
		rd(ADDR_ICTL, 32'h0, "interrupts after reset");
		rd(ADDR_CNT2, 32'h0, "count after reset");
		give_verdict();
	end
endmodule
